// ==== smt_pkg.sv ====
package smt_pkg;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned NUM_OUT = 4;

    // Register offsets
    localparam logic [3:0] OFF_CTRL0 = 4'h0;
    localparam logic [3:0] OFF_CTRL1 = 4'h1;
    localparam logic [3:0] OFF_OPTION = 4'h2;
    localparam logic [3:0] OFF_OUTCTL = 4'h3;
    localparam logic [3:0] OFF_CAPIO = 4'h4;
    localparam logic [3:0] OFF_TRIGIO = 4'h5;
    localparam logic [3:0] OFF_CCR0 = 4'h6;
    localparam logic [3:0] OFF_CCR1 = 4'h7;
    localparam logic [3:0] OFF_CCR2 = 4'h8;
    localparam logic [3:0] OFF_CCR3 = 4'h9;
    localparam logic [3:0] OFF_COUNT = 4'ha;

    // Field positions
    localparam int unsigned BIT_CE = 7;
    localparam int unsigned BIT_EST = 6;
    localparam int unsigned BIT_EEE = 5;
    localparam int unsigned MD_LSB = 0;
    localparam int unsigned MD_W = 3;
    localparam int unsigned BIT_CCS0 = 0;
    localparam int unsigned ES_LSB = 2;
    localparam logic [7:0] TRIGIO_MASK = 8'h0c;
    localparam logic [7:0] CAPIO_MASK = 8'h03;

    // Reset values and count limit
    localparam logic [15:0] CCR_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] REG8_RST = 8'h00;

    // Edge selections
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Mode field encodings
    localparam logic [2:0] MD_INTERVAL = 3'h0;
    localparam logic [2:0] MD_EVENT = 3'h1;
    localparam logic [2:0] MD_EXTTRIG = 3'h2;
    localparam logic [2:0] MD_ONESHOT = 3'h3;
    localparam logic [2:0] MD_PWM = 3'h4;
    localparam logic [2:0] MD_FREERUN = 3'h5;
    localparam logic [2:0] MD_PWIDTH = 3'h6;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_RUN} smt_state_t;

    typedef struct packed {
        logic ext_clock_enable;
        logic [2:0] mode;
    } smt_ctrl1_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } smt_bus_req_t;
endpackage : smt_pkg

// ==== smt_timer.sv ====
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module smt_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [smt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic trigger_in_pin,
    input wire logic ext_clk_pin,
    output logic [smt_pkg::NUM_OUT-1:0] out_pin_q,
    output logic [smt_pkg::NUM_OUT-1:0] cmp_irq
);
    import smt_pkg::*;

    smt_bus_req_t req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Input synchronisers and edge history
    logic [2:0] trig_sync_ff, nxt_trig_sync;
    logic [2:0] eclk_sync_ff, nxt_eclk_sync;

    always_comb begin
        nxt_trig_sync = {trig_sync_ff[1:0], trigger_in_pin};
        nxt_eclk_sync = {eclk_sync_ff[1:0], ext_clk_pin};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trig_sync_ff <= 3'h0;
            eclk_sync_ff <= 3'h0;
        end else begin
            trig_sync_ff <= nxt_trig_sync;
            eclk_sync_ff <= nxt_eclk_sync;
        end
    end

    logic trig_rise, trig_fall, eclk_rise;
    assign trig_rise = trig_sync_ff[1] & ~trig_sync_ff[2];
    assign trig_fall = ~trig_sync_ff[1] & trig_sync_ff[2];
    assign eclk_rise = eclk_sync_ff[1] & ~eclk_sync_ff[2];

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            EDGE_RISE: edge_hit = r;
            EDGE_FALL: edge_hit = f;
            EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Software registers
    logic count_enable_ff, nxt_count_enable;
    smt_ctrl1_t ctrl1_ff, nxt_ctrl1;
    logic capcomp0_select_ff, nxt_capcomp0_select;
    logic [7:0] outctl_ff, nxt_outctl;
    logic [7:0] capio_ff, nxt_capio;
    logic [7:0] trigio_ff, nxt_trigio;
    logic [15:0] ccr_ff [NUM_OUT];
    logic [15:0] nxt_ccr [NUM_OUT];
    logic soft_trigger;

    // Counter engine state
    smt_state_t state_ff, nxt_state;
    logic [15:0] count_ff, nxt_count;
    logic [15:0] cmp_ff [NUM_OUT];
    logic [15:0] nxt_cmp [NUM_OUT];
    logic [NUM_OUT-1:0] raw_ff, nxt_raw;
    logic [NUM_OUT-1:0] irq_ff, nxt_irq;
    logic [NUM_OUT-1:0] pin_ff, nxt_pin;
    logic [15:0] rdata_ff, nxt_rdata;

    logic [2:0] mode;
    logic trig_mode, batch_mode, ccr0_capture;
    logic tick, trig_ok, cap_edge, cycle_end;
    logic [NUM_OUT-1:0] match;

    assign mode = ctrl1_ff.mode;
    assign trig_mode = (mode == MD_EXTTRIG) || (mode == MD_ONESHOT);
    assign batch_mode = (mode == MD_EXTTRIG) || (mode == MD_PWM);
    assign ccr0_capture = (mode == MD_PWIDTH) ||
                          ((mode == MD_FREERUN) && capcomp0_select_ff);
    assign soft_trigger = req.wr && (req.addr == OFF_CTRL1) && req.wdata[BIT_EST];
    assign trig_ok = trig_mode && (soft_trigger ||
                     edge_hit(trigio_ff[ES_LSB +: 2], trig_rise, trig_fall));
    assign cap_edge = edge_hit(capio_ff[1:0], trig_rise, trig_fall);
    // External count clock in event mode or when selected
    assign tick = (ctrl1_ff.ext_clock_enable || (mode == MD_EVENT)) ? eclk_rise : 1'b1;

    // Equality compare: a value passed over by a rewrite is simply missed
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_match
            assign match[gi] = (state_ff == ST_RUN) && tick && (count_ff == cmp_ff[gi]);
        end
    endgenerate

    assign cycle_end = match[0] && !ccr0_capture && (mode != MD_FREERUN);

    // Register write path
    always_comb begin
        nxt_count_enable = count_enable_ff;
        nxt_ctrl1 = ctrl1_ff;
        nxt_capcomp0_select = capcomp0_select_ff;
        nxt_outctl = outctl_ff;
        nxt_capio = capio_ff;
        nxt_trigio = trigio_ff;
        for (int i = 0; i < NUM_OUT; i++) begin
            nxt_ccr[i] = ccr_ff[i];
        end
        if (req.wr) begin
            case (req.addr)
                OFF_CTRL0: nxt_count_enable = req.wdata[BIT_CE];
                OFF_CTRL1: begin
                    nxt_ctrl1.ext_clock_enable = req.wdata[BIT_EEE];
                    nxt_ctrl1.mode = req.wdata[MD_LSB +: MD_W];
                end
                OFF_OPTION: nxt_capcomp0_select = req.wdata[BIT_CCS0];
                OFF_OUTCTL: nxt_outctl = req.wdata[7:0];
                OFF_CAPIO: nxt_capio = req.wdata[7:0] & CAPIO_MASK;
                OFF_TRIGIO: nxt_trigio = req.wdata[7:0] & TRIGIO_MASK;
                OFF_CCR0: nxt_ccr[0] = req.wdata;
                OFF_CCR1: nxt_ccr[1] = req.wdata;
                OFF_CCR2: nxt_ccr[2] = req.wdata;
                OFF_CCR3: nxt_ccr[3] = req.wdata;
                default: ;
            endcase
        end
        // Capture overrides a same-cycle write so the event is not lost
        if (ccr0_capture && (state_ff == ST_RUN) && cap_edge) begin
            nxt_ccr[0] = count_ff;
        end
    end

    // Counter, compare buffers and outputs
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_raw = raw_ff;
        nxt_irq = '0;
        for (int i = 0; i < NUM_OUT; i++) begin
            // Anytime write follows the register; batch write reloads at cycle end
            if (!batch_mode || (state_ff != ST_RUN) || cycle_end) begin
                nxt_cmp[i] = nxt_ccr[i];
            end else begin
                nxt_cmp[i] = cmp_ff[i];
            end
        end
        if (!count_enable_ff) begin
            nxt_state = ST_IDLE;
            nxt_count = '0;
            nxt_raw = '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = trig_mode ? ST_WAIT_TRIG : ST_RUN;
                    nxt_count = '0;
                end
                ST_WAIT_TRIG: begin
                    if (trig_ok) begin
                        nxt_state = ST_RUN;
                        nxt_count = '0;
                    end
                end
                ST_RUN: begin
                    if (trig_ok && (mode == MD_EXTTRIG)) begin
                        nxt_count = '0;
                        nxt_raw[NUM_OUT-1:1] = '0;
                    end else if (tick) begin
                        if (cycle_end) begin
                            nxt_count = '0;
                        end else begin
                            nxt_count = count_ff + 16'h0001;
                        end
                        if ((mode == MD_PWIDTH) && cap_edge) begin
                            nxt_count = '0;
                        end
                        case (mode)
                            MD_EXTTRIG, MD_PWM: begin
                                for (int k = 1; k < NUM_OUT; k++) begin
                                    if (match[k]) begin
                                        nxt_raw[k] = 1'b1;
                                    end
                                end
                                if (cycle_end) begin
                                    nxt_raw[NUM_OUT-1:1] = '0;
                                    nxt_raw[0] = ~raw_ff[0];
                                end
                            end
                            MD_ONESHOT: begin
                                if (match[1]) begin
                                    nxt_raw[1] = 1'b1;
                                end
                                if (match[0]) begin
                                    nxt_raw[1] = 1'b0;
                                    nxt_state = ST_WAIT_TRIG;
                                    nxt_count = '0;
                                end
                            end
                            default: begin
                                for (int k = 0; k < NUM_OUT; k++) begin
                                    if (match[k] && !(k == 0 && ccr0_capture)) begin
                                        nxt_raw[k] = ~raw_ff[k];
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
        for (int k = 0; k < NUM_OUT; k++) begin
            nxt_irq[k] = match[k] && !(k == 0 && ccr0_capture);
        end
    end

    // Pin drive: enable gates, level sets the idle level, and the active polarity on outputs 1 to 3 only
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_pin
            if (gi == 0) begin : g_out0
                assign nxt_pin[gi] = outctl_ff[2*gi] ? nxt_raw[gi] : outctl_ff[2*gi+1];
            end else begin : g_outk
                assign nxt_pin[gi] = outctl_ff[2*gi] ?
                                     (nxt_raw[gi] ^ outctl_ff[2*gi+1]) :
                                     outctl_ff[2*gi+1];
            end
        end
    endgenerate

    // Read path, data one cycle after the strobe
    always_comb begin
        nxt_rdata = '0;
        if (req.rd) begin
            case (req.addr)
                OFF_CTRL0: nxt_rdata = {8'h00, count_enable_ff, 7'h00};
                OFF_CTRL1: nxt_rdata = {10'h000, ctrl1_ff.ext_clock_enable, 2'h0, ctrl1_ff.mode};
                OFF_OPTION: nxt_rdata = {15'h0000, capcomp0_select_ff};
                OFF_OUTCTL: nxt_rdata = {8'h00, outctl_ff};
                OFF_CAPIO: nxt_rdata = {8'h00, capio_ff};
                OFF_TRIGIO: nxt_rdata = {8'h00, trigio_ff};
                OFF_CCR0: nxt_rdata = ccr_ff[0];
                OFF_CCR1: nxt_rdata = ccr_ff[1];
                OFF_CCR2: nxt_rdata = ccr_ff[2];
                OFF_CCR3: nxt_rdata = ccr_ff[3];
                OFF_COUNT: nxt_rdata = count_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_enable_ff <= 1'b0;
            ctrl1_ff <= '0;
            capcomp0_select_ff <= 1'b0;
            outctl_ff <= REG8_RST;
            capio_ff <= REG8_RST;
            trigio_ff <= REG8_RST;
            for (int i = 0; i < NUM_OUT; i++) begin
                ccr_ff[i] <= CCR_RST;
                cmp_ff[i] <= CCR_RST;
            end
            state_ff <= ST_IDLE;
            count_ff <= '0;
            raw_ff <= '0;
            irq_ff <= '0;
            pin_ff <= '0;
            rdata_ff <= '0;
        end else begin
            count_enable_ff <= nxt_count_enable;
            ctrl1_ff <= nxt_ctrl1;
            capcomp0_select_ff <= nxt_capcomp0_select;
            outctl_ff <= nxt_outctl;
            capio_ff <= nxt_capio;
            trigio_ff <= nxt_trigio;
            for (int i = 0; i < NUM_OUT; i++) begin
                ccr_ff[i] <= nxt_ccr[i];
                cmp_ff[i] <= nxt_cmp[i];
            end
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            raw_ff <= nxt_raw;
            irq_ff <= nxt_irq;
            pin_ff <= nxt_pin;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign out_pin_q = pin_ff;
    assign cmp_irq = irq_ff;
endmodule : smt_timer

// ==== smt_timer_checker.sv ====
`timescale 1ns/10ps
module smt_timer_checker
    import smt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [smt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic trigger_in_pin,
    input wire logic ext_clk_pin,
    input wire logic [smt_pkg::NUM_OUT-1:0] out_pin_q,
    input wire logic [smt_pkg::NUM_OUT-1:0] cmp_irq
);
    logic [2:0] mode_ff;
    logic [2:0] nxt_mode;
    logic [7:0] outctl_ff;
    logic [7:0] nxt_outctl;
    logic [1:0] age_ff;
    logic [1:0] nxt_age;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Shadow of mode and output control, age counts cycles since the last output write
    always_comb begin
        nxt_mode = mode_ff;
        nxt_outctl = outctl_ff;
        nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
        if (reg_wr && reg_addr == OFF_CTRL1) begin
            nxt_mode = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == OFF_OUTCTL) begin
            nxt_outctl = reg_wdata[7:0];
            nxt_age = 2'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_ff <= 3'h0;
            outctl_ff <= 8'h00;
            age_ff <= 2'h0;
        end else begin
            mode_ff <= nxt_mode;
            outctl_ff <= nxt_outctl;
            age_ff <= nxt_age;
        end
    end

    sequence s_ccr0_write(v);
        reg_wr && reg_addr == OFF_CCR0 && reg_wdata == v;
    endsequence

    sequence s_quiet;
        cmp_irq == 4'h0;
    endsequence

    property p_ccr0_back;
        logic [15:0] v;
        (reg_wr && reg_addr == OFF_CCR0, v = reg_wdata) ##0 s_ccr0_write(v) ##1 !reg_wr
            ##1 (reg_rd && reg_addr == OFF_CCR0) |=> reg_rdata == v;
    endproperty

    chk_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    chk_ccr0_back: assert property (p_ccr0_back)
        else $error("compare 0 readback differs from write");
    chk_trig_mask: assert property (reg_rd && reg_addr == OFF_TRIGIO |=>
        (reg_rdata & ~16'h000c) == 16'h0000)
        else $error("trigger io reserved bits not zero");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > OFF_COUNT |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_out0_level: assert property (age_ff == 2'h3 && !outctl_ff[0] |->
        out_pin_q[0] == outctl_ff[1])
        else $error("disabled output 0 not at level bit");
    chk_out_idle: assert property (age_ff == 2'h3 |->
        ((out_pin_q[3:1] ^ {outctl_ff[7], outctl_ff[5], outctl_ff[3]})
        & ~{outctl_ff[6], outctl_ff[4], outctl_ff[2]}) == 3'h0)
        else $error("disabled output not at inactive level");
    chk_shot_set: assert property (mode_ff == MD_ONESHOT && outctl_ff[2] && cmp_irq[1] |->
        out_pin_q[1] == ~outctl_ff[3])
        else $error("output 1 not active at compare 1 match");
    chk_shot_halt: assert property (mode_ff == MD_ONESHOT && outctl_ff[2] && cmp_irq[0] |->
        out_pin_q[1] == outctl_ff[3] ##1 s_quiet [*8])
        else $error("one shot did not end and halt");
    chk_pw_no_irq0: assert property (mode_ff == MD_PWIDTH |-> !cmp_irq[0])
        else $error("compare 0 match in capture only mode");
endmodule : smt_timer_checker

bind smt_timer smt_timer_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_in_pin(trigger_in_pin), .ext_clk_pin(ext_clk_pin),
    .out_pin_q(out_pin_q), .cmp_irq(cmp_irq));

// ==== smt_pin_partner.sv ====
`timescale 1ns/10ps
module smt_pin_partner #(
    parameter int HOLD = 6
) (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic eclk_on,
    output logic trigger_in_pin,
    output logic ext_clk_pin
);
    int hold = 0;

    // External count clock toggles every cycle while asked, rests low otherwise
    always @(posedge core_clk) begin
        if (fire) begin
            hold <= HOLD;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
        trigger_in_pin <= fire || (hold > 1);
        ext_clk_pin <= eclk_on && !ext_clk_pin;
    end
endmodule : smt_pin_partner

// ==== smt_timer_tb.sv ====
`timescale 1ns/10ps
module smt_timer_tb;
    import smt_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fire = 1'b0;
    logic eclk_on = 1'b0;
    logic rd_seen = 1'b0;
    logic [15:0] reg_rdata;
    logic trigger_in_pin;
    logic ext_clk_pin;
    logic [3:0] out_pin_q;
    logic [3:0] cmp_irq;
    logic [31:0] note;
    logic [15:0] rv;
    logic [31:0] rd_q[$];
    logic [7:0] irq_q[$];
    int errors = 0;
    int samples_checked = 0;

    always #10 core_clk = ~core_clk;

    smt_timer uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_in_pin(trigger_in_pin), .ext_clk_pin(ext_clk_pin),
        .out_pin_q(out_pin_q), .cmp_irq(cmp_irq));

    smt_pin_partner partner (.core_clk(core_clk), .fire(fire), .eclk_on(eclk_on),
        .trigger_in_pin(trigger_in_pin), .ext_clk_pin(ext_clk_pin));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] mask);
        rd_q.push_back({mask, exp});
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    task automatic pulse;
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        @(posedge core_clk);
    endtask : pulse

    task automatic wait_irqs;
        int n;
        n = 0;
        while (irq_q.size() != 0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (irq_q.size() != 0) begin
            errors++;
            wrap_up;
        end
    endtask : wait_irqs

    // Read answers and every interrupt pulse are matched against the oldest note
    always @(posedge core_clk) begin
        if (rd_seen) begin
            note = rd_q.pop_front();
            check("reg_rdata", note[15:0], reg_rdata & note[31:16]);
        end
        if (rst_n && cmp_irq !== 4'h0) begin
            note = (irq_q.size() != 0) ? {24'h0, irq_q.pop_front()} : 32'h0;
            check("cmp_irq_out", note[15:0], {8'h00, cmp_irq, out_pin_q});
        end
        rd_seen <= reg_rd;
    end

    initial begin
        rv = 16'($urandom(93));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFF_CCR0, CCR_RST, 16'hffff);
        wr(OFF_TRIGIO, 16'h00ff);
        rd(OFF_TRIGIO, 16'h000c, 16'hffff);
        rd(4'hb, 16'h0000, 16'hffff);
        rv = 16'($urandom);
        wr(OFF_CCR0, rv);
        rd(OFF_CCR0, rv, 16'hffff);
        wr(OFF_OUTCTL, 16'h000a);
        repeat (3) @(posedge core_clk);
        check("out_pin_q", 16'h0003, {12'h000, out_pin_q});
        // One-shot run, first by software trigger then by the trigger pin
        wr(OFF_OUTCTL, 16'h0004);
        wr(OFF_TRIGIO, 16'h0004);
        wr(OFF_CCR1, 16'h0002);
        wr(OFF_CCR2, 16'hffff);
        wr(OFF_CCR3, 16'hffff);
        wr(OFF_CCR0, 16'h0004);
        wr(OFF_CTRL1, {13'h0000, MD_ONESHOT});
        wr(OFF_CTRL0, 16'h0080);
        repeat (20) @(posedge core_clk);
        irq_q.push_back(8'h22);
        irq_q.push_back(8'h10);
        wr(OFF_CTRL1, {9'h000, 1'b1, 3'h0, MD_ONESHOT});
        wait_irqs;
        repeat (10) @(posedge core_clk);
        irq_q.push_back(8'h22);
        irq_q.push_back(8'h10);
        pulse;
        wait_irqs;
        wr(OFF_CTRL0, 16'h0000);
        // Free-running with register 0 as compare, rewritten while counting
        wr(OFF_CCR1, 16'hffff);
        wr(OFF_CCR0, 16'h0005);
        wr(OFF_CTRL1, {13'h0000, MD_FREERUN});
        wr(OFF_OPTION, 16'h0000);
        irq_q.push_back(8'h10);
        wr(OFF_CTRL0, 16'h0080);
        wait_irqs;
        rv = 16'($urandom) | 16'h8000;
        wr(OFF_CCR0, rv);
        rd(OFF_CCR0, rv, 16'hffff);
        wr(OFF_CTRL0, 16'h0000);
        // Same mode as capture: no compare 0 pulse, edge stores the count
        wr(OFF_CCR0, 16'h0005);
        wr(OFF_OPTION, 16'h0001);
        wr(OFF_CAPIO, 16'h0001);
        wr(OFF_CTRL0, 16'h0080);
        repeat (20) @(posedge core_clk);
        pulse;
        repeat (10) @(posedge core_clk);
        wr(OFF_CTRL0, 16'h0000);
        rd(OFF_CCR0, 16'h0010, 16'hfff0);
        wr(OFF_CTRL1, {13'h0000, MD_PWIDTH});
        // Pulse width: each rising edge stores the count and restarts it
        wr(OFF_CCR0, 16'hffff);
        wr(OFF_CTRL0, 16'h0080);
        repeat (20) @(posedge core_clk);
        pulse;
        repeat (10) @(posedge core_clk);
        pulse;
        repeat (10) @(posedge core_clk);
        wr(OFF_CTRL0, 16'h0000);
        rd(OFF_CCR0, 16'h0008, 16'hfff8);
        // Trigger pulse mode started by software: PWM on output 1, square wave on output 0
        wr(OFF_CCR1, 16'h0004);
        wr(OFF_CCR0, 16'h0007);
        wr(OFF_OUTCTL, 16'h0005);
        wr(OFF_CTRL1, {13'h0000, MD_EXTTRIG});
        wr(OFF_CTRL0, 16'h0080);
        irq_q.push_back(8'h22);
        irq_q.push_back(8'h11);
        irq_q.push_back(8'h23);
        irq_q.push_back(8'h10);
        wr(OFF_CTRL1, {9'h000, 1'b1, 3'h0, MD_EXTTRIG});
        wait_irqs;
        wr(OFF_CTRL0, 16'h0000);
        // Event count: nothing moves until the external clock runs
        wr(OFF_CAPIO, 16'h0000);
        wr(OFF_CCR0, 16'h0003);
        wr(OFF_CTRL1, {13'h0000, MD_EVENT});
        wr(OFF_CTRL0, 16'h0080);
        repeat (20) @(posedge core_clk);
        irq_q.push_back(8'h11);
        eclk_on <= 1'b1;
        wait_irqs;
        wr(OFF_CTRL0, 16'h0000);
        eclk_on <= 1'b0;
        wrap_up;
    end
endmodule : smt_timer_tb
